// >>> hdl/twbf_pkg.sv
/*
  Shared constants and types for the two-wire bus framing ends.
  Assumes a single system clock of 40 MHz on both ends.
*/
package twbf_pkg;

  localparam int CLK_PERIOD_NS = 25;

  // The internal write must end within 5 ms at room temperature and 7 ms over range.
  localparam int INTERNAL_WRITE_DURATION_ROOM_NS = 5000000;
  localparam int INTERNAL_WRITE_DURATION_FULL_NS = 7000000;
  localparam int INTERNAL_WRITE_CYCLES = INTERNAL_WRITE_DURATION_ROOM_NS / CLK_PERIOD_NS;
  localparam int WR_CNT_W = 18;

  // Host serial clock: four quarters of 250 ns give a 1 MHz bit rate.
  localparam int SCL_QUARTER_NS = 250;
  localparam int SCL_QUARTER_CYCLES = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QCNT_W = 4;

  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_RECOVER_CLOCK = 4'h8;
  localparam int DIR_BIT = 0;
  localparam int SYNC_STAGES = 3;
  localparam logic LINE_IDLE = 1'h1;

  typedef enum logic [2:0]
  {
    TWBF_D_IDLE = 3'b000,
    TWBF_D_RX = 3'b001,
    TWBF_D_ACK = 3'b010,
    TWBF_D_TX = 3'b011,
    TWBF_D_RACK = 3'b100,
    TWBF_D_WAIT = 3'b101
  } twbf_dev_state_e;

  typedef enum logic [2:0]
  {
    TWBF_H_IDLE = 3'b000,
    TWBF_H_START = 3'b001,
    TWBF_H_BIT = 3'b010,
    TWBF_H_STOP = 3'b011,
    TWBF_H_RECOV = 3'b100
  } twbf_host_state_e;

  typedef enum logic [2:0]
  {
    TWBF_OP_START = 3'b000,
    TWBF_OP_WRITE = 3'b001,
    TWBF_OP_READ = 3'b010,
    TWBF_OP_STOP = 3'b011,
    TWBF_OP_RECOVER = 3'b100
  } twbf_op_e;

endpackage

// >>> hdl/twbf_if.sv
/*
  Two-wire link between the host end and the device end.
  Assumes an external pull-up on the data line; the clock is driven by the host alone.
*/
`timescale 1ns/10ps
interface twbf_if;
  logic scl;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic sda;

  // Wired-AND of both open-drain drivers with the pull-up.
  assign sda = !((host_sda_oe && !host_sda_out) || (dev_sda_oe && !dev_sda_out));

  modport dev
  (
    input scl,
    input sda,
    output dev_sda_out,
    output dev_sda_oe
  );

  modport host
  (
    output scl,
    input sda,
    output host_sda_out,
    output host_sda_oe
  );
endinterface

// >>> hdl/twbf_dev.sv
/*
  Device end of the two-wire link: start and stop detection, byte reception with
  acknowledge, byte transmission, standby after reads and the self-timed write.
  Assumes the host keeps to the bus rules; both link lines are asynchronous inputs.
*/
// Contract
// (R1) Data changes only while clock is low.
// (R2) Data edge with clock high is start/stop.
// (R3) Falling data, clock high: start before command.
// (R4) Rising data, clock high: stop ends transfer.
// (R5) Stop after a read enters standby.
// (R6) Bytes move as eight-bit groups both ways.
// (R7) Device pulls data low on ninth clock.
// (R8) Host recovers: nine clocks, then start. Code stops clocking early once data is seen high.
// (R9) Internal write ends within 5 ms.
// (R10) Sample on rising, change after falling clock.
// (R11) Device only pulls low or releases.
// (R12) Busy writing: ignore commands, withhold acknowledge.
`timescale 1ns/10ps
module twbf_dev
#(
  parameter int unsigned WRITE_CYCLES = twbf_pkg::INTERNAL_WRITE_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic resetn,
  twbf_if.dev bus,
  output logic [7:0] rx_data_q,
  output logic rx_valid_q,
  output logic rx_first_q,
  input wire logic [7:0] tx_data,
  output logic tx_load_q,
  output logic read_mode_q,
  output logic standby_q,
  output logic write_busy_q
);
  import twbf_pkg::*;

  logic [SYNC_STAGES-1:0] scl_sync_q;
  logic [SYNC_STAGES-1:0] sda_sync_q;
  logic scl_f_q;
  logic sda_f_q;
  logic scl_p_q;
  logic sda_p_q;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  twbf_dev_state_e state_q;
  logic [3:0] bitcnt_q;
  logic [7:0] shreg_q;
  logic first_q;
  logic nack_q;
  logic wr_pend_q;
  logic pull_q;
  logic [WR_CNT_W-1:0] wr_cnt_q;

  // Three-stage synchroniser; a level counts once stages two and three agree.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      scl_sync_q <= {SYNC_STAGES{LINE_IDLE}};
      sda_sync_q <= {SYNC_STAGES{LINE_IDLE}};
      scl_f_q <= LINE_IDLE;
      sda_f_q <= LINE_IDLE;
      scl_p_q <= LINE_IDLE;
      sda_p_q <= LINE_IDLE;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[1:0], bus.scl};
      sda_sync_q <= {sda_sync_q[1:0], bus.sda};
      if (scl_sync_q[2] == scl_sync_q[1])
      begin
        scl_f_q <= scl_sync_q[1];
      end
      if (sda_sync_q[2] == sda_sync_q[1])
      begin
        sda_f_q <= sda_sync_q[1];
      end
      scl_p_q <= scl_f_q;
      sda_p_q <= sda_f_q;
    end
  end

  assign scl_rise = scl_f_q && !scl_p_q;
  assign scl_fall = !scl_f_q && scl_p_q;
  assign start_ev = scl_f_q && scl_p_q && sda_p_q && !sda_f_q; // (R2) (R3)
  assign stop_ev = scl_f_q && scl_p_q && !sda_p_q && sda_f_q; // (R2) (R4)

  // The device only ever pulls low or lets go of the data line.
  assign bus.dev_sda_out = 1'h0; // (R11)
  assign bus.dev_sda_oe = pull_q; // (R11)

  // Framing state machine.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= TWBF_D_IDLE;
      bitcnt_q <= 4'h0;
      shreg_q <= 8'h00;
      first_q <= 1'h0;
      nack_q <= 1'h0;
      wr_pend_q <= 1'h0;
      pull_q <= 1'h0;
      read_mode_q <= 1'h0;
      rx_data_q <= 8'h00;
      rx_valid_q <= 1'h0;
      rx_first_q <= 1'h0;
      tx_load_q <= 1'h0;
    end
    else
    begin
      rx_valid_q <= 1'h0;
      tx_load_q <= 1'h0;
      if (start_ev)
      begin
        state_q <= write_busy_q ? TWBF_D_WAIT : TWBF_D_RX; // (R3) (R12)
        bitcnt_q <= 4'h0;
        first_q <= 1'h1;
        read_mode_q <= 1'h0;
        wr_pend_q <= 1'h0;
        pull_q <= 1'h0;
      end
      else if (stop_ev)
      begin
        state_q <= TWBF_D_IDLE; // (R4)
        wr_pend_q <= 1'h0;
        pull_q <= 1'h0;
      end
      else
      begin
        case (state_q)
          TWBF_D_RX:
          begin
            if (scl_rise)
            begin
              shreg_q <= {shreg_q[6:0], sda_f_q}; // (R10) (R6)
              bitcnt_q <= bitcnt_q + 4'h1;
            end
            else if (scl_fall && bitcnt_q == BYTE_BITS)
            begin
              state_q <= TWBF_D_ACK;
              pull_q <= 1'h1; // (R7)
              rx_valid_q <= 1'h1;
              rx_data_q <= shreg_q;
              rx_first_q <= first_q;
              if (first_q)
              begin
                read_mode_q <= shreg_q[DIR_BIT];
              end
              else if (!read_mode_q)
              begin
                wr_pend_q <= 1'h1;
              end
            end
          end
          TWBF_D_ACK:
          begin
            if (scl_fall)
            begin
              first_q <= 1'h0;
              bitcnt_q <= 4'h0;
              if (read_mode_q)
              begin
                state_q <= TWBF_D_TX;
                shreg_q <= tx_data;
                tx_load_q <= 1'h1;
                pull_q <= !tx_data[7]; // (R10)
              end
              else
              begin
                state_q <= TWBF_D_RX;
                pull_q <= 1'h0; // (R7)
              end
            end
          end
          TWBF_D_TX:
          begin
            if (scl_rise)
            begin
              bitcnt_q <= bitcnt_q + 4'h1;
            end
            else if (scl_fall)
            begin
              if (bitcnt_q == BYTE_BITS)
              begin
                state_q <= TWBF_D_RACK; // (R6)
                pull_q <= 1'h0;
              end
              else
              begin
                shreg_q <= {shreg_q[6:0], 1'h0};
                pull_q <= !shreg_q[6]; // (R10)
              end
            end
          end
          TWBF_D_RACK:
          begin
            if (scl_rise)
            begin
              nack_q <= sda_f_q; // (R10)
            end
            else if (scl_fall)
            begin
              bitcnt_q <= 4'h0;
              if (nack_q)
              begin
                state_q <= TWBF_D_WAIT;
              end
              else
              begin
                state_q <= TWBF_D_TX;
                shreg_q <= tx_data;
                tx_load_q <= 1'h1;
                pull_q <= !tx_data[7]; // (R10)
              end
            end
          end
          TWBF_D_IDLE, TWBF_D_WAIT:
          begin
            pull_q <= 1'h0;
          end
          default:
          begin
            state_q <= TWBF_D_IDLE;
            pull_q <= 1'h0;
          end
        endcase
      end
    end
  end

  // Self-timed internal write, started by a stop that ends a write with data.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      write_busy_q <= 1'h0;
      wr_cnt_q <= '0;
    end
    else if (stop_ev && wr_pend_q && !write_busy_q)
    begin
      write_busy_q <= 1'h1; // (R9)
      wr_cnt_q <= WR_CNT_W'(WRITE_CYCLES - 1);
    end
    else if (write_busy_q)
    begin
      if (wr_cnt_q == '0)
      begin
        write_busy_q <= 1'h0; // (R9)
      end
      else
      begin
        wr_cnt_q <= wr_cnt_q - WR_CNT_W'(1);
      end
    end
  end

  // Standby after a read sequence, left at the next start.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      standby_q <= 1'h0;
    end
    else if (start_ev)
    begin
      standby_q <= 1'h0;
    end
    else if (stop_ev && read_mode_q)
    begin
      standby_q <= 1'h1; // (R5)
    end
  end

endmodule // twbf_dev

// >>> hdl/twbf_host.sv
/*
  Host end of the two-wire link: makes the serial clock by division and frames
  start, stop, byte writes, byte reads and bus recovery on command.
  Assumes commands arrive on the system clock; the data line is an asynchronous input.
*/
`timescale 1ns/10ps
module twbf_host
(
  input wire logic sys_clk,
  input wire logic resetn,
  twbf_if.host bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire twbf_pkg::twbf_op_e cmd_op,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_ack,
  output logic done_q,
  output logic [7:0] rd_data_q,
  output logic dev_ack_q
);
  import twbf_pkg::*;

  logic [SYNC_STAGES-1:0] sda_sync_q;
  logic sda_f_q;
  twbf_host_state_e state_q;
  logic [QCNT_W-1:0] qcnt_q;
  logic [1:0] phase_q;
  logic [3:0] bits_q;
  logic [8:0] out_q;
  logic [7:0] in_q;
  logic scl_q;
  logic pull_q;
  logic accept;
  logic tick;

  assign cmd_ready = (state_q == TWBF_H_IDLE);
  assign accept = cmd_valid && cmd_ready;
  assign tick = (qcnt_q == '0) && !cmd_ready;
  assign bus.scl = scl_q;
  assign bus.host_sda_out = 1'h0;
  assign bus.host_sda_oe = pull_q;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sda_sync_q <= {SYNC_STAGES{LINE_IDLE}};
      sda_f_q <= LINE_IDLE;
    end
    else
    begin
      sda_sync_q <= {sda_sync_q[1:0], bus.sda};
      if (sda_sync_q[2] == sda_sync_q[1])
      begin
        sda_f_q <= sda_sync_q[1];
      end
    end
  end

  // Quarter-bit enable divider, restarted with every accepted command.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      qcnt_q <= '0;
    end
    else if (accept || qcnt_q == '0)
    begin
      qcnt_q <= QCNT_W'(SCL_QUARTER_CYCLES - 1);
    end
    else
    begin
      qcnt_q <= qcnt_q - QCNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= TWBF_H_IDLE;
      phase_q <= 2'h0;
      bits_q <= 4'h0;
      out_q <= 9'h1FF;
      in_q <= 8'h00;
      scl_q <= LINE_IDLE;
      pull_q <= 1'h0;
      done_q <= 1'h0;
      rd_data_q <= 8'h00;
      dev_ack_q <= 1'h0;
    end
    else
    begin
      done_q <= 1'h0;
      if (accept)
      begin
        phase_q <= 2'h0;
        bits_q <= 4'h0;
        case (cmd_op)
          TWBF_OP_START: state_q <= TWBF_H_START; // (R3)
          TWBF_OP_WRITE:
          begin
            state_q <= TWBF_H_BIT;
            out_q <= {cmd_data, 1'h1};
          end
          TWBF_OP_READ:
          begin
            state_q <= TWBF_H_BIT;
            out_q <= {8'hFF, !cmd_ack};
          end
          TWBF_OP_STOP: state_q <= TWBF_H_STOP;
          TWBF_OP_RECOVER: state_q <= TWBF_H_RECOV; // (R8)
          default: state_q <= TWBF_H_IDLE;
        endcase
      end
      else if (tick)
      begin
        phase_q <= phase_q + 2'h1;
        case (state_q)
          TWBF_H_START:
          begin
            case (phase_q)
              2'h0: pull_q <= 1'h0;
              2'h1: scl_q <= 1'h1;
              2'h2: pull_q <= 1'h1; // (R3)
              default:
              begin
                scl_q <= 1'h0;
                done_q <= 1'h1;
                state_q <= TWBF_H_IDLE;
              end
            endcase
          end
          TWBF_H_BIT:
          begin
            case (phase_q)
              2'h0: pull_q <= !out_q[8]; // (R1)
              2'h1: pull_q <= !out_q[8];
              2'h2: scl_q <= 1'h1;
              default:
              begin
                scl_q <= 1'h0;
                in_q <= {in_q[6:0], sda_f_q};
                out_q <= {out_q[7:0], 1'h1};
                bits_q <= bits_q + 4'h1;
                if (bits_q == BYTE_BITS)
                begin
                  rd_data_q <= in_q; // (R6)
                  dev_ack_q <= !sda_f_q;
                  done_q <= 1'h1;
                  state_q <= TWBF_H_IDLE;
                end
              end
            endcase
          end
          TWBF_H_STOP:
          begin
            case (phase_q)
              2'h0: pull_q <= 1'h1;
              2'h1: scl_q <= 1'h1;
              2'h2: pull_q <= 1'h0;
              default:
              begin
                done_q <= 1'h1;
                state_q <= TWBF_H_IDLE;
              end
            endcase
          end
          TWBF_H_RECOV:
          begin
            case (phase_q)
              2'h0:
              begin
                scl_q <= 1'h0;
                pull_q <= 1'h0;
              end
              2'h1: scl_q <= 1'h0;
              2'h2: scl_q <= 1'h1;
              default:
              begin
                bits_q <= bits_q + 4'h1;
                if (sda_f_q || bits_q == LAST_RECOVER_CLOCK)
                begin
                  state_q <= TWBF_H_START; // (R8)
                end
              end
            endcase
          end
          default: state_q <= TWBF_H_IDLE;
        endcase
      end
    end
  end

endmodule // twbf_host

// >>> dv/twbf_chk.sv
/*
  Wire-level checker for the two-wire link between host and device ends.
  Assumes it is instantiated beside the interface and sampled on sys_clk.
*/
`timescale 1ns/10ps
module twbf_chk
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic scl,
  input wire logic host_sda_out,
  input wire logic host_sda_oe,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  logic scl_q;
  logic sda_q;
  logic [3:0] rise_cnt_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  // Counts clock rises since the last start, wrapping from nine back to one, so the ninth rise of each byte is the acknowledge clock.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      rise_cnt_q <= 4'h0;
    else if (scl && sda_q && !sda)
      rise_cnt_q <= 4'h0;
    else if (scl && !scl_q)
      rise_cnt_q <= (rise_cnt_q == 4'h9) ? 4'h1 : rise_cnt_q + 4'h1;
  end
  a_dev_pull_only: assert property (dev_sda_oe |-> !dev_sda_out)
    else $error("device drives data high");
  a_host_pull_only: assert property (host_sda_oe |-> !host_sda_out)
    else $error("host drives data high");
  a_dev_edge_low: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl))
    else $error("device data changed with clock high");
  a_dev_hold_high: assert property ($rose(scl) |=> $stable(dev_sda_oe)[*8])
    else $error("device data moved during clock high");
  a_scl_spacing: assert property ($changed(scl) |=> $stable(scl)[*8])
    else $error("serial clock phase too short");
  a_data_hold_high: assert property ($rose(scl) |=> $stable(sda)[*8])
    else $error("data moved early in clock high");
  a_ack_ninth: assert property ($rose(scl) && rise_cnt_q == 4'h8 && dev_sda_oe
    |=> (dev_sda_oe && !sda)[*8])
    else $error("acknowledge not held through ninth clock");
  a_start_by_host: assert property (scl && sda_q && !sda |-> host_sda_oe && !dev_sda_oe)
    else $error("start not made by host");
  a_stop_released: assert property (scl && !sda_q && sda |=> !dev_sda_oe[*8])
    else $error("device pulls data after stop");
  c_start: cover property (scl && sda_q && !sda);
  c_stop: cover property (scl && !sda_q && sda);
  c_ack: cover property ($rose(scl) && rise_cnt_q == 4'h8 && dev_sda_oe);
endmodule // twbf_chk

// >>> dv/testbench.sv
/*
  Self-checking bench joining host and device ends through the link interface.
  Assumes a 40 MHz sys_clk and a shortened internal write count.
*/
`timescale 1ns/10ps
`define CHK(nm, e, g) begin logic [31:0] ev, gv; ev = 32'(e); gv = 32'(g); checked++; \
  if (gv !== ev) begin n_errors++; $display("MISMATCH %s expected %h seen %h", nm, ev, gv); end end
module testbench;
  import twbf_pkg::*;
  localparam int WCYC = 1000;
  logic sys_clk = 1'h0;
  logic resetn = 1'h0;
  logic cmd_valid = 1'h0;
  logic cmd_ready;
  twbf_op_e cmd_op = TWBF_OP_START;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_ack = 1'h0;
  logic done_q, dev_ack_q, rx_valid_q, rx_first_q, tx_load_q, read_mode_q;
  logic standby_q, write_busy_q;
  logic [7:0] rd_data_q, rx_data_q;
  logic [7:0] tx_data = 8'h5A;
  int n_errors = 0;
  int checked = 0;
  int busy_len = 0;
  logic busy_run = 1'h0;
  logic tx_zero = 1'h0;
  logic [8:0] rx_qu[$];
  logic [7:0] tx_qu[$];
  twbf_if bus();
  twbf_host twbf_host_i (.sys_clk(sys_clk), .resetn(resetn), .bus(bus), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_ack(cmd_ack),
    .done_q(done_q), .rd_data_q(rd_data_q), .dev_ack_q(dev_ack_q));
  twbf_dev #(.WRITE_CYCLES(WCYC)) twbf_dev_i (.sys_clk(sys_clk), .resetn(resetn), .bus(bus),
    .rx_data_q(rx_data_q), .rx_valid_q(rx_valid_q), .rx_first_q(rx_first_q), .tx_data(tx_data),
    .tx_load_q(tx_load_q), .read_mode_q(read_mode_q), .standby_q(standby_q),
    .write_busy_q(write_busy_q));
  twbf_chk twbf_chk_i (.sys_clk(sys_clk), .resetn(resetn), .scl(bus.scl),
    .host_sda_out(bus.host_sda_out), .host_sda_oe(bus.host_sda_oe),
    .dev_sda_out(bus.dev_sda_out), .dev_sda_oe(bus.dev_sda_oe), .sda(bus.sda));
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    if (rx_valid_q === 1'h1)
      rx_qu.push_back({rx_first_q, rx_data_q});
    if (tx_load_q === 1'h1)
    begin
      tx_qu.push_back(tx_data);
      tx_data <= tx_zero ? 8'h00 : 8'($urandom);
    end
    // Length of the latest busy run; a stop during busy must not start a new one.
    busy_run <= (write_busy_q === 1'h1);
    if (write_busy_q === 1'h1)
      busy_len <= busy_run ? busy_len + 1 : 1;
  end
  function automatic logic [7:0] addr(input logic rd);
    return {7'($urandom), rd};
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmd(input twbf_op_e op, input logic [7:0] d, input logic a);
    int i;
    @(posedge sys_clk);
    cmd_valid <= 1'h1;
    cmd_op <= op;
    cmd_data <= d;
    cmd_ack <= a;
    @(posedge sys_clk);
    cmd_valid <= 1'h0;
    @(negedge sys_clk);
    `CHK("ready", 1'h0, cmd_ready)
    for (i = 0; i < 900 && done_q !== 1'h1; i++)
      @(negedge sys_clk);
    if (i == 900)
    begin
      n_errors++;
      end_sim();
    end
  endtask
  task automatic wr(input logic [7:0] d, input logic first);
    cmd(TWBF_OP_WRITE, d, 1'h0);
    `CHK("ack", 1'h1, dev_ack_q)
    `CHK("rx byte", {first, d}, rx_qu.pop_front())
  endtask
  task automatic wait_busy();
    int i;
    for (i = 0; i < 1500 && write_busy_q !== 1'h0; i++)
      @(negedge sys_clk);
    if (i == 1500)
    begin
      n_errors++;
      end_sim();
    end
    `CHK("busy length", WCYC, busy_len)
  endtask
  initial
  begin
    logic [7:0] a;
    void'($urandom(32'hcf48));
    repeat (6) @(posedge sys_clk);
    resetn <= 1'h1;
    repeat (2)
    begin
      a = addr(1'h0);
      cmd(TWBF_OP_START, 8'h00, 1'h0);
      wr(a, 1'h1);
      repeat (1 + $urandom_range(2))
        wr(8'($urandom), 1'h0);
      cmd(TWBF_OP_STOP, 8'h00, 1'h0);
      `CHK("busy", 1'h1, write_busy_q)
      cmd(TWBF_OP_START, 8'h00, 1'h0);
      cmd(TWBF_OP_WRITE, a, 1'h0);
      `CHK("poll ack", 1'h0, dev_ack_q)
      `CHK("poll rx", 0, rx_qu.size())
      cmd(TWBF_OP_STOP, 8'h00, 1'h0);
      wait_busy();
    end
    $display("write test done");
    cmd(TWBF_OP_START, 8'h00, 1'h0);
    wr(addr(1'h1), 1'h1);
    `CHK("read mode", 1'h1, read_mode_q)
    cmd(TWBF_OP_READ, 8'h00, 1'h1);
    `CHK("read byte", tx_qu.pop_front(), rd_data_q)
    tx_zero = 1'h1;
    cmd(TWBF_OP_READ, 8'h00, 1'h0);
    `CHK("read byte", tx_qu.pop_front(), rd_data_q)
    cmd(TWBF_OP_STOP, 8'h00, 1'h0);
    `CHK("standby", 1'h1, standby_q)
    cmd(TWBF_OP_START, 8'h00, 1'h0);
    `CHK("standby", 1'h0, standby_q)
    $display("read test done");
    // Zero bytes are queued now, so the device holds the line low when the host abandons the read.
    wr(addr(1'h1), 1'h1);
    cmd(TWBF_OP_RECOVER, 8'h00, 1'h0);
    wr(8'hFE, 1'h1);
    wr(8'hFF, 1'h0);
    cmd(TWBF_OP_STOP, 8'h00, 1'h0);
    `CHK("standby", 1'h0, standby_q)
    wait_busy();
    $display("recovery test done");
    end_sim();
  end
endmodule // testbench
